// ==== core/strap_decoder_regs.svh ====
/*
 * Constants for the drive role strap decoder.
 * Assumes inclusion by bare name from core/.
 */
`ifndef STRAP_DECODER_REGS_SVH
`define STRAP_DECODER_REGS_SVH

// Register byte offsets
`define ROLE_STATUS_OFFS   12'h000
`define ROLE_CTRL_OFFS     12'h004
// Status fields
`define ST_MASTER_BIT      0
`define ST_SLV_PRES_BIT    1
`define ST_CSEL_BIT        2
`define ST_DSEL_BIT        3
`define ST_PARK_BIT        4
`define ST_CABLE_BIT       5
// Control fields
`define CTRL_RESAMPLE_BIT  0
// Reset values
`define CTRL_RESET         32'h0000_0000
// AXI responses
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// ==== core/strap_decoder_pkg.sv ====
/*
 * Types for the drive role strap decoder.
 * Assumes no other package.
 */
package strap_decoder_pkg;
    // Decoded drive role
    typedef enum logic [1:0] {
        ROLE_SLAVE      = 2'b00,
        ROLE_MASTER     = 2'b01,
        ROLE_MASTER_SP  = 2'b10
    } role_t;
endpackage

// ==== core/drive_role_strap_decoder.sv ====
/*
 * Drive role strap decoder with AXI4-Lite status access.
 * Assumes straps and cable level are synchronous to aclk and steady
 * around reset release.
 */
// Implementation choices: the address map and the AXI4-Lite register port.
`include "strap_decoder_regs.svh"

// What this block does
// - Cable select alone takes role from cable level
// - Cable low gives master role
// - Cable high or open gives slave
// - Drive-select jumper alone gives master, drive zero
// - No jumpers gives slave, drive one
// - Both jumpers: master with slave present
// - Parking jumper never affects role
// - Bias parking pins to sense jumper
// - Drive-select role independent of cable position
module drive_role_strap_decoder
    import strap_decoder_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Strap inputs, high means jumper fitted
    input  wire logic        cable_select_strap,
    input  wire logic        drive_select_strap,
    input  wire logic        parking_strap,
    // Cable-select line level, low means grounded
    input  wire logic        cable_select_level,
    // Parking pin bias drive
    output logic             park_bias_en,
    // Decoded role
    output logic             is_master,
    output logic             slave_present_strap,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // Whole module state
    typedef struct packed {
        logic        sample_pend;   // Latch straps on next edge
        role_t       role;          // Held decoded role
        logic [3:0]  straps;        // Captured jumper and cable levels
        logic        aw_got;        // Write address held
        logic [11:0] aw_addr;
        logic        w_got;         // Write data held
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } state_t;

    state_t st_r;   // Registered state
    state_t st_nxt; // Next state

    // Role decode; parking deliberately unused, cable level used only with cable select alone
    function automatic role_t decode_role(input logic cs, input logic ds, input logic lvl);
        role_t r;
        r = ROLE_SLAVE;
        if (cs && ds)
            r = ROLE_MASTER_SP;
        else if (cs)
            r = lvl ? ROLE_SLAVE : ROLE_MASTER;
        else if (ds)
            r = ROLE_MASTER;
        else
            r = ROLE_SLAVE;
        return r;
    endfunction

    // Status word from current state
    function automatic logic [31:0] status_word(input state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`ST_MASTER_BIT]   = (s.role != ROLE_SLAVE);
        w[`ST_SLV_PRES_BIT] = (s.role == ROLE_MASTER_SP);
        w[`ST_CSEL_BIT]     = s.straps[3];
        w[`ST_DSEL_BIT]     = s.straps[2];
        w[`ST_PARK_BIT]     = s.straps[1];
        w[`ST_CABLE_BIT]    = s.straps[0];
        return w;
    endfunction

    // Word-index match of a bus address against a register offset
    function automatic logic addr_hits(input logic [11:0] addr, input logic [11:0] offs);
        return addr[11:2] == offs[11:2]; // Byte lanes ignored, one word per register
    endfunction

    logic do_write; // Both halves of a write present
    logic do_read;  // Read address accepted

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        do_write = st_r.aw_got && st_r.w_got && !st_r.bvalid;
        do_read  = s_axi_arvalid && !st_r.rvalid;
        // Capture straps once after reset release or on software request
        if (st_r.sample_pend) begin
            st_nxt.sample_pend = 1'b0;
            st_nxt.straps = {cable_select_strap, drive_select_strap, parking_strap, cable_select_level};
            st_nxt.role = decode_role(cable_select_strap, drive_select_strap, cable_select_level);
        end
        // Accept address and data independently
        if (s_axi_awvalid && !st_r.aw_got) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_got) begin
            st_nxt.w_got = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        // Perform write and answer
        if (do_write) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            if (addr_hits(st_r.aw_addr, `ROLE_CTRL_OFFS)) begin
                st_nxt.bresp = `RESP_OKAY;
                // Resample request; role otherwise stays put
                if (st_r.w_strb[0] && st_r.w_data[`CTRL_RESAMPLE_BIT])
                    st_nxt.sample_pend = 1'b1;
            end else if (addr_hits(st_r.aw_addr, `ROLE_STATUS_OFFS)) begin
                st_nxt.bresp = `RESP_OKAY; // Read-only, write ignored
            end else begin
                st_nxt.bresp = `RESP_SLVERR;
            end
        end
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;
        // Reads answer one cycle after address acceptance
        if (do_read) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `RESP_OKAY;
            if (addr_hits(s_axi_araddr, `ROLE_STATUS_OFFS))
                st_nxt.rdata = status_word(st_r);
            else if (addr_hits(s_axi_araddr, `ROLE_CTRL_OFFS))
                st_nxt.rdata = `CTRL_RESET;
            else begin
                st_nxt.rdata = 32'h0000_0000;
                st_nxt.rresp = `RESP_SLVERR;
            end
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    // State register; reset arms the strap capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.sample_pend <= 1'b1;
            st_r.role <= ROLE_SLAVE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign park_bias_en        = 1'b1;
    assign is_master           = (st_r.role != ROLE_SLAVE);
    assign slave_present_strap = (st_r.role == ROLE_MASTER_SP);
    assign s_axi_awready       = !st_r.aw_got;
    assign s_axi_wready        = !st_r.w_got;
    assign s_axi_bvalid        = st_r.bvalid;
    assign s_axi_bresp         = st_r.bresp;
    assign s_axi_arready       = !st_r.rvalid;
    assign s_axi_rvalid        = st_r.rvalid;
    assign s_axi_rresp         = st_r.rresp;
    assign s_axi_rdata         = st_r.rdata;

    // Cable select with grounded level yields master
    cs_master_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.sample_pend && cable_select_strap && !drive_select_strap && !cable_select_level
        |=> is_master && !slave_present_strap)
        else $error("cable low did not give master");
    // Cable select with high level yields slave
    cs_slave_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.sample_pend && cable_select_strap && !drive_select_strap && cable_select_level
        |=> !is_master)
        else $error("cable high did not give slave");
    // Cable select without drive select takes role from cable level
    cs_source_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.sample_pend && cable_select_strap && !drive_select_strap
        |=> is_master == !$past(cable_select_level))
        else $error("cable select role not from cable");
    // Drive select alone yields master
    ds_master_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.sample_pend && !cable_select_strap && drive_select_strap
        |=> is_master && !slave_present_strap)
        else $error("drive select did not give master");
    // Drive select role ignores cable level
    ds_position_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.sample_pend && !cable_select_strap && drive_select_strap && cable_select_level
        |=> is_master)
        else $error("drive select role follows cable");
    // No jumpers yields slave
    no_jumper_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.sample_pend && !cable_select_strap && !drive_select_strap
        |=> !is_master)
        else $error("no jumpers did not give slave");
    // Both jumpers yields master with slave present
    both_jumper_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.sample_pend && cable_select_strap && drive_select_strap
        |=> is_master && slave_present_strap)
        else $error("both jumpers not master with slave");
    // Role stays put between captures
    role_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_r.sample_pend |=> $stable(st_r.role))
        else $error("role changed without capture");
    // Parking bias always on
    park_bias_a: assert property (@(posedge aclk) disable iff (!aresetn)
        park_bias_en)
        else $error("parking bias off");

endmodule

// ==== tb/cable_host_model.sv ====
/*
 * Host cable model that drives the cable-select line.
 * Assumes the bench chooses the connector the drive sits on.
 */
module cable_host_model (
    // Clock
    input  wire logic aclk,
    // Connector position, high means far end
    input  wire logic far_end,
    // Cable-select line seen by the drive
    output logic      cable_select_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Near end grounded, far end open and pulled high; lags a cycle like a slow cable
    always_ff @(posedge aclk) begin
        cable_select_level <= far_end;
    end
endmodule

// ==== tb/drive_role_strap_decoder_tb.sv ====
/*
 * Self-checking bench for the drive role strap decoder.
 * Assumes the core/ files and the cable model are compiled first.
 */
`include "strap_decoder_regs.svh"
module drive_role_strap_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, far_end;  // Clock, reset, cable position
    logic        cable_select_strap, drive_select_strap, parking_strap;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire         cable_select_level, park_bias_en, is_master, slave_present_strap;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    int          n_errors, checks_done, cycles;  // Counters
    integer      seed;                           // Random seed
    logic [33:0] rq[$];                          // Expected read response and data
    logic [1:0]  bq[$];                          // Expected write response
    logic [1:0]  role_x;                         // Expected {slave present, master}

    drive_role_strap_decoder i_dut (.aclk, .aresetn, .cable_select_strap, .drive_select_strap,
        .parking_strap, .cable_select_level, .park_bias_en, .is_master, .slave_present_strap,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    cable_host_model i_cable (.aclk, .far_end, .cable_select_level);

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Role from straps and cable level
    function automatic logic [1:0] role_of(input logic cs, input logic ds, input logic lvl);
        if (cs && ds) return 2'b11;
        if (cs) return {1'b0, ~lvl};
        return {1'b0, ds};
    endfunction

    // Compare and count
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ap, wp;
        ap = 1'b1;
        wp = 1'b1;
        // Start on an edge so back-to-back calls never reassign a ready
        @(posedge aclk);
        bq.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (ap || wp) begin
            @(posedge aclk);
            if (ap && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                ap = 1'b0;
            end
            if (wp && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                wp = 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    // Read: ready held until data seen
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        // Start on an edge so back-to-back calls never reassign a ready
        @(posedge aclk);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // Scoreboard: oldest note against each response
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) check(s_axi_bresp, bq.pop_front());
    end

    // Hang guard, well above the few hundred cycles needed
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            summarize();
        end
    end

    // Main sequence
    initial begin
        seed = 32'h2c4a;
        aresetn = 1'b0;
        {cable_select_strap, drive_select_strap, parking_strap, far_end} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // Every strap and cable combination, each captured by its own reset
        for (int i = 0; i < 16; i++) begin
            @(posedge aclk);
            {cable_select_strap, drive_select_strap, parking_strap, far_end} <= i[3:0];
            aresetn <= 1'b0;
            repeat (2) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (3) @(posedge aclk);
            role_x = role_of(i[3], i[2], i[0]);
            #1 check({slave_present_strap, is_master}, role_x);
            check(park_bias_en, 1'b1);
            rd(`ROLE_STATUS_OFFS, {`RESP_OKAY, 26'h0, i[0], i[1], i[2], i[3], role_x});
        end
        // Straps moved without reset: role must hold until a resample
        @(posedge aclk);
        {cable_select_strap, drive_select_strap} <= 2'b00;
        {parking_strap, far_end} <= 2'($random(seed));
        repeat (4) @(posedge aclk);
        #1 check({slave_present_strap, is_master}, 2'b11);
        wr(`ROLE_CTRL_OFFS, $random(seed) | 32'h1, `RESP_OKAY);
        repeat (3) @(posedge aclk);
        #1 check({slave_present_strap, is_master}, 2'b00);
        rd(`ROLE_CTRL_OFFS, {`RESP_OKAY, 32'h0});
        // Control write without its low byte strobe must not resample
        @(posedge aclk);
        drive_select_strap <= 1'b1;
        s_axi_wstrb <= 4'he;
        wr(`ROLE_CTRL_OFFS, 32'h1, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        repeat (3) @(posedge aclk);
        #1 check({slave_present_strap, is_master}, 2'b00);
        // Status is read-only; unmapped places answer with an error
        wr(`ROLE_STATUS_OFFS, 32'hffff_ffff, `RESP_OKAY);
        rd(`ROLE_STATUS_OFFS, {`RESP_OKAY, 26'h0, far_end, parking_strap, 4'h0});
        rd(12'h008, {`RESP_SLVERR, 32'h0});
        wr(12'h00c, 32'h1, `RESP_SLVERR);
        repeat (2) @(posedge aclk);
        summarize();
    end
endmodule
